// *** dcc_comparator_ctrl.v ***
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "dcc_consts.vh"
module dcc_comparator_ctrl #(
  parameter NCOMP = 2
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire [7:0]       regAddr,
  input  wire [7:0]       regWrData,
  input  wire             regWr,
  input  wire             regRd,
  output reg  [7:0]       regRdData,
  input  wire [NCOMP-1:0] rawCompare,
  input  wire [NCOMP-1:0] portLatch,
  input  wire [NCOMP-1:0] pinIsOutput,
  input  wire             timerClkTick,
  output reg  [NCOMP-1:0] compEnable,
  output reg  [2*NCOMP-1:0] invInputSel,
  output reg  [NCOMP-1:0] refSelect,
  output reg  [NCOMP-1:0] pinOut,
  output reg  [NCOMP-1:0] pinOe,
  output reg              timerGate,
  output reg              timerCompOut,
  output reg              irqReq,
  output reg              wakeReq
);

  function ctrlHit;
    input [7:0] addr;
    input integer idx;
    begin
      ctrlHit = (addr == (`DCC_ADDR_CTRL1 + idx[7:0]));
    end
  endfunction

  // ---------------- shared state
  reg  [`DCC_PHASE_W-1:0] phase_ff;
  reg  [`DCC_PHASE_W-1:0] nxt_phase;
  wire                    firstPhase;
  wire [NCOMP-1:0]        syncCompare;

  reg  [8*NCOMP-1:0] ctrl_ff;
  reg  [7:0]         aux_ff;
  reg  [NCOMP-1:0]   flag_ff;
  reg  [NCOMP-1:0]   irqEn_ff;
  reg                gie_ff;
  reg                peripheral_irq_enable_ff;

  reg  [NCOMP-1:0]   sampled_ff;
  reg  [NCOMP-1:0]   snapshot_ff;
  reg  [NCOMP-1:0]   mismatchDly_ff;
  wire [NCOMP-1:0]   result;
  wire [NCOMP-1:0]   mismatch;
  wire [NCOMP-1:0]   mismatchRise;
  wire [NCOMP-1:0]   ctrlTouch;

  reg                timerHeld_ff;
  reg  [7:0]         nxt_rdData;

  wire auxWr    = regWr && (regAddr == `DCC_ADDR_AUX);
  wire flagWr   = regWr && (regAddr == `DCC_ADDR_FLAG);
  wire ienWr    = regWr && (regAddr == `DCC_ADDR_IEN);
  wire intCtlWr = regWr && (regAddr == `DCC_ADDR_INTCTL);

  dcc_sync #(
    .WIDTH (NCOMP)
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn (rawCompare),
    .syncOut (syncCompare)
  );

  // instruction cycle is four clocks; phase zero is the first phase
  always @* begin
    nxt_phase = phase_ff + {{(`DCC_PHASE_W-1){1'b0}}, 1'b1};
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      phase_ff <= {`DCC_PHASE_W{1'b0}};
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  assign firstPhase = (phase_ff == {`DCC_PHASE_W{1'b0}});

  // ---------------- per comparator
  genvar gi;
  generate
    for (gi = 0; gi < NCOMP; gi = gi + 1) begin : g_comp
      wire on    = ctrl_ff[8*gi + `DCC_CTL_ON];
      wire pol   = ctrl_ff[8*gi + `DCC_CTL_POL];
      wire oe    = ctrl_ff[8*gi + `DCC_CTL_OE];
      wire ctlWr = regWr && ctrlHit(regAddr, gi);
      wire ctlRd = regRd && ctrlHit(regAddr, gi);

      // a write begins with a read, so it touches the snapshot too
      assign ctrlTouch[gi] = ctlWr || ctlRd;

      // disabled core gives a low raw level
      assign result[gi] = (on & syncCompare[gi]) ^ pol;

      assign mismatch[gi]     = snapshot_ff[gi] ^ sampled_ff[gi];
      assign mismatchRise[gi] = mismatch[gi] & ~mismatchDly_ff[gi];

      always @(posedge clk) begin
        if (!reset_n) begin
          ctrl_ff[8*gi +: 8] <= `DCC_CTL_RESET;
        end else if (ctlWr) begin
          ctrl_ff[8*gi +: 8] <= regWrData & `DCC_CTL_WMASK;
        end
      end

      always @(posedge clk) begin
        if (!reset_n) begin
          sampled_ff[gi]     <= 1'b0;
          snapshot_ff[gi]    <= 1'b0;
          mismatchDly_ff[gi] <= 1'b0;
        end else begin
          if (firstPhase) begin
            sampled_ff[gi] <= result[gi];
          end
          if (ctrlTouch[gi]) begin
            snapshot_ff[gi] <= sampled_ff[gi];
          end
          mismatchDly_ff[gi] <= mismatch[gi];
        end
      end

      // hardware set beats a same-cycle software clear
      always @(posedge clk) begin
        if (!reset_n) begin
          flag_ff[gi] <= 1'b0;
        end else if (mismatchRise[gi]) begin
          flag_ff[gi] <= 1'b1;
        end else if (flagWr) begin
          flag_ff[gi] <= regWrData[`DCC_FLAG_C1 + gi];
        end
      end

      always @(posedge clk) begin
        if (!reset_n) begin
          irqEn_ff[gi] <= 1'b0;
        end else if (ienWr) begin
          irqEn_ff[gi] <= regWrData[`DCC_FLAG_C1 + gi];
        end
      end

      // pin path follows the live result, not the phase-zero sample; registered every clock
      always @(posedge clk) begin
        if (!reset_n) begin
          pinOut[gi]               <= 1'b0;
          pinOe[gi]                <= 1'b0;
          compEnable[gi]           <= 1'b0;
          refSelect[gi]            <= 1'b0;
          invInputSel[2*gi +: 2]   <= 2'h0;
        end else begin
          pinOut[gi]             <= oe ? (on & result[gi]) : portLatch[gi];
          pinOe[gi]              <= pinIsOutput[gi];
          compEnable[gi]         <= on;
          refSelect[gi]          <= ctrl_ff[8*gi + `DCC_CTL_REF];
          invInputSel[2*gi +: 2] <= ctrl_ff[8*gi + `DCC_CTL_CH_LO +: 2];
        end
      end
    end
  endgenerate

  // ---------------- auxiliary and interrupt control registers
  always @(posedge clk) begin
    if (!reset_n) begin
      aux_ff <= `DCC_AUX_RESET;
    end else if (auxWr) begin
      aux_ff <= regWrData & `DCC_AUX_WMASK;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      gie_ff  <= 1'b0;
      peripheral_irq_enable_ff <= 1'b0;
    end else if (intCtlWr) begin
      gie_ff  <= regWrData[`DCC_INT_GIE];
      peripheral_irq_enable_ff <= regWrData[`DCC_INT_PERIPHERAL_IRQ_ENABLE];
    end
  end

  // ---------------- companion timer link, second comparator only
  // sync mode holds the result steady between timer clock ticks
  always @(posedge clk) begin
    if (!reset_n) begin
      timerHeld_ff <= 1'b0;
      timerGate    <= 1'b1;
      timerCompOut <= 1'b0;
    end else begin
      if (timerClkTick) begin
        timerHeld_ff <= sampled_ff[NCOMP-1];
      end
      timerCompOut <= aux_ff[`DCC_AUX_SYNC] ? timerHeld_ff : sampled_ff[NCOMP-1];
      timerGate    <= aux_ff[`DCC_AUX_GATE] ? timerCompOut : 1'b1;
    end
  end

  // ---------------- interrupt request and wake
  always @(posedge clk) begin
    if (!reset_n) begin
      irqReq  <= 1'b0;
      wakeReq <= 1'b0;
    end else begin
      irqReq  <= (|(flag_ff & irqEn_ff)) & peripheral_irq_enable_ff & gie_ff;
      wakeReq <= (|(flag_ff & irqEn_ff)) & peripheral_irq_enable_ff;
    end
  end

  // ---------------- read port
  integer ri;
  always @* begin
    nxt_rdData = 8'h00;
    case (regAddr)
      `DCC_ADDR_CTRL1: begin
        nxt_rdData = ctrl_ff[7:0];
        nxt_rdData[`DCC_CTL_OUT] = sampled_ff[0];
      end
      `DCC_ADDR_CTRL2: begin
        nxt_rdData = ctrl_ff[15:8];
        nxt_rdData[`DCC_CTL_OUT] = sampled_ff[NCOMP-1];
      end
      `DCC_ADDR_AUX: begin
        nxt_rdData = aux_ff;
        nxt_rdData[`DCC_AUX_MC1] = sampled_ff[0];
        nxt_rdData[`DCC_AUX_MC2] = sampled_ff[NCOMP-1];
      end
      `DCC_ADDR_FLAG: begin
        for (ri = 0; ri < NCOMP; ri = ri + 1) begin
          nxt_rdData[`DCC_FLAG_C1 + ri] = flag_ff[ri];
        end
      end
      `DCC_ADDR_IEN: begin
        for (ri = 0; ri < NCOMP; ri = ri + 1) begin
          nxt_rdData[`DCC_FLAG_C1 + ri] = irqEn_ff[ri];
        end
      end
      `DCC_ADDR_INTCTL: begin
        nxt_rdData[`DCC_INT_GIE]  = gie_ff;
        nxt_rdData[`DCC_INT_PERIPHERAL_IRQ_ENABLE] = peripheral_irq_enable_ff;
      end
      default: begin
        nxt_rdData = 8'h00;
      end
    endcase
  end

  // data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (!reset_n) begin
      regRdData <= 8'h00;
    end else if (regRd) begin
      regRdData <= nxt_rdData;
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule // dcc_comparator_ctrl
`default_nettype wire

// *** dcc_consts.vh ***
`ifndef DCC_CONSTS_VH
`define DCC_CONSTS_VH

`define DCC_ADDR_CTRL1   8'h00
`define DCC_ADDR_CTRL2   8'h01
`define DCC_ADDR_AUX     8'h02
`define DCC_ADDR_FLAG    8'h03
`define DCC_ADDR_IEN     8'h04
`define DCC_ADDR_INTCTL  8'h05

`define DCC_CTL_ON       7
`define DCC_CTL_OUT      6
`define DCC_CTL_OE       5
`define DCC_CTL_POL      4
`define DCC_CTL_REF      2
`define DCC_CTL_CH_HI    1
`define DCC_CTL_CH_LO    0
`define DCC_CTL_WMASK    8'hb7
`define DCC_CTL_RESET    8'h00

`define DCC_AUX_MC1      7
`define DCC_AUX_MC2      6
`define DCC_AUX_GATE     1
`define DCC_AUX_SYNC     0
`define DCC_AUX_WMASK    8'h03
`define DCC_AUX_RESET    8'h00

`define DCC_FLAG_C1      3
`define DCC_FLAG_C2      4
`define DCC_INT_GIE      7
`define DCC_INT_PERIPHERAL_IRQ_ENABLE     6

`define DCC_PHASES       4
`define DCC_PHASE_W      2

`endif

// *** dcc_sync.v ***
`timescale 1ns/1ps
`default_nettype none
module dcc_sync #(
  parameter WIDTH = 2
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_ff;
  reg [WIDTH-1:0] stage2_ff;

  // first stage feeds only the second
  always @(posedge clk) begin
    if (!reset_n) begin
      stage1_ff <= {WIDTH{1'b0}};
      stage2_ff <= {WIDTH{1'b0}};
    end else begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
    end
  end

  assign syncOut = stage2_ff;

endmodule // dcc_sync
`default_nettype wire

// *** dcc_analog_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcc_analog_model (
  input  wire logic [1:0]  compEnable,
  input  wire logic [3:0]  invInputSel,
  input  wire logic [1:0]  refSelect,
  input  wire logic [31:0] chanLevel,
  input  wire logic [7:0]  plusLevel,
  input  wire logic [7:0]  refLevel,
  output var  logic [1:0]  rawCompare
);
  // an unpowered core gives no valid decision, so it is held low
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      rawCompare[i] = compEnable[i] &
        ((refSelect[i] ? refLevel : plusLevel) > chanLevel[{invInputSel[2*i+:2], 3'b000}+:8]);
    end
  end
endmodule // dcc_analog_model
`default_nettype wire

// *** dcc_comparator_ctrl_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcc_comparator_ctrl_checker #(
  parameter NCOMP = 2
) (
  input wire logic               clk,
  input wire logic               reset_n,
  input wire logic [7:0]         regAddr,
  input wire logic [7:0]         regWrData,
  input wire logic               regWr,
  input wire logic               regRd,
  input wire logic [7:0]         regRdData,
  input wire logic [NCOMP-1:0]   portLatch,
  input wire logic [NCOMP-1:0]   pinIsOutput,
  input wire logic [NCOMP-1:0]   compEnable,
  input wire logic [2*NCOMP-1:0] invInputSel,
  input wire logic [NCOMP-1:0]   refSelect,
  input wire logic [NCOMP-1:0]   pinOut,
  input wire logic [NCOMP-1:0]   pinOe,
  input wire logic               timerGate,
  input wire logic               irqReq,
  input wire logic               wakeReq
);
  logic       oeSh_ff;
  logic       onSh_ff;
  wire        wr1 = regWr && regAddr == 8'h00;
  wire        wr2 = regWr && regAddr == 8'h01;
  wire  [3:0] ctlF = {regWrData[7], regWrData[2], regWrData[1:0]};
  // output and comparator enables as ctrl1 holds them; the enable port lags by one cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      oeSh_ff <= 1'b0;
      onSh_ff <= 1'b0;
    end else if (wr1) begin
      oeSh_ff <= regWrData[5];
      onSh_ff <= regWrData[7];
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  AST_CTL1_WR: assert property (
    wr1 |=> ##1 {compEnable[0], refSelect[0], invInputSel[1:0]} == $past(ctlF, 2)) else $error("ctrl1 fields");
  AST_CTL2_WR: assert property (
    wr2 |=> ##1 {compEnable[1], refSelect[1], invInputSel[3:2]} == $past(ctlF, 2)) else $error("ctrl2 fields");
  AST_PIN_LATCH: assert property (
    $past(reset_n) && !oeSh_ff |=> pinOut[0] == $past(portLatch[0])) else $error("pin latch");
  AST_PIN_OFF: assert property (
    oeSh_ff && !onSh_ff |=> !pinOut[0]) else $error("pin off");
  AST_PIN_DIR: assert property (
    $past(reset_n) |-> pinOe == $past(pinIsOutput)) else $error("pin dir");
  AST_IRQ_WAKE: assert property (
    irqReq |-> wakeReq) else $error("irq without wake");
  AST_RESET: assert property (
    $rose(reset_n) |-> compEnable == 0 && invInputSel == 0 && !irqReq && timerGate) else $error("reset");
  AST_RD_IDLE: assert property (
    !regRd |=> regRdData == 8'h00) else $error("read idle");
  cover property (irqReq);
  cover property (wakeReq && !irqReq);
  cover property (wr1 && regWrData[5]);
endmodule // dcc_comparator_ctrl_checker
bind dcc_comparator_ctrl dcc_comparator_ctrl_checker #(.NCOMP(NCOMP)) chk (
  .clk         (clk),
  .reset_n     (reset_n),
  .regAddr     (regAddr),
  .regWrData   (regWrData),
  .regWr       (regWr),
  .regRd       (regRd),
  .regRdData   (regRdData),
  .portLatch   (portLatch),
  .pinIsOutput (pinIsOutput),
  .compEnable  (compEnable),
  .invInputSel (invInputSel),
  .refSelect   (refSelect),
  .pinOut      (pinOut),
  .pinOe       (pinOe),
  .timerGate   (timerGate),
  .irqReq      (irqReq),
  .wakeReq     (wakeReq)
);
`default_nettype wire

// *** test_dcc_comparator_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_dcc_comparator_ctrl;
  logic        clk = 0;
  logic        reset_n = 0;
  logic [7:0]  regAddr = 0;
  logic [7:0]  regWrData = 0;
  logic        regWr = 0;
  logic        regRd = 0;
  logic [1:0]  portLatch = 0;
  logic [1:0]  pinIsOutput = 0;
  logic        timerClkTick = 0;
  logic [31:0] chanLevel = 32'h80802080;
  logic [7:0]  plusLevel = 8'h40;
  logic [7:0]  refLevel = 8'hc0;
  logic [7:0]  ctl;
  logic        res;
  wire  [7:0]  regRdData;
  wire  [1:0]  rawCompare, compEnable, refSelect, pinOut, pinOe;
  wire  [3:0]  invInputSel;
  wire         timerGate, timerCompOut, irqReq, wakeReq;
  int          failures = 0;
  int          n_compared = 0;
  always #25 clk = ~clk;
  dcc_comparator_ctrl uut (
    .clk          (clk),
    .reset_n      (reset_n),
    .regAddr      (regAddr),
    .regWrData    (regWrData),
    .regWr        (regWr),
    .regRd        (regRd),
    .regRdData    (regRdData),
    .rawCompare   (rawCompare),
    .portLatch    (portLatch),
    .pinIsOutput  (pinIsOutput),
    .timerClkTick (timerClkTick),
    .compEnable   (compEnable),
    .invInputSel  (invInputSel),
    .refSelect    (refSelect),
    .pinOut       (pinOut),
    .pinOe        (pinOe),
    .timerGate    (timerGate),
    .timerCompOut (timerCompOut),
    .irqReq       (irqReq),
    .wakeReq      (wakeReq)
  );
  dcc_analog_model far (
    .compEnable  (compEnable),
    .invInputSel (invInputSel),
    .refSelect   (refSelect),
    .chanLevel   (chanLevel),
    .plusLevel   (plusLevel),
    .refLevel    (refLevel),
    .rawCompare  (rawCompare)
  );
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(name, exp, regRdData);
  endtask
  // moves the plus input, then reads the flags and the request lines
  task automatic step(input logic [7:0] p, input logic [7:0] f, input logic [1:0] q, input string name);
    @(posedge clk);
    plusLevel <= p;
    repeat (8) @(posedge clk);
    rd(8'h03, f, name);
    chk("irq", {6'h0, q}, {6'h0, wakeReq, irqReq});
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    end_sim;
  end
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 8; a++) rd(a[7:0], 8'h00, "reset value");
    chk("gate", 8'h01, {7'h0, timerGate});
    $display("test reset done");
    for (int k = 0; k < 32; k++) begin
      ctl = {k[4], 2'b00, k[3], 1'b0, k[2], k[1:0]};
      res = k[3] ^ (k[4] & ((k[2] ? refLevel : plusLevel) > chanLevel[8*k[1:0]+:8]));
      wr(8'h00, ctl);
      repeat (8) @(posedge clk);
      rd(8'h00, ctl | {1'b0, res, 6'h0}, "ctrl1");
      rd(8'h02, {res, 7'h0}, "mirror1");
    end
    wr(8'h01, 8'h82);
    wr(8'h02, 8'h02);
    repeat (8) @(posedge clk);
    #1;
    chk("gate", 8'h00, {7'h0, timerGate});
    wr(8'h01, 8'h81);
    repeat (8) @(posedge clk);
    rd(8'h01, 8'hc1, "ctrl2");
    rd(8'h02, 8'h42, "mirror2");
    chk("gate", 8'h01, {7'h0, timerGate});
    // sync mode: no tick yet, so the timer still sees the reset-time hold
    wr(8'h02, 8'h03);
    repeat (4) @(posedge clk);
    #1;
    chk("sync held", 8'h00, {6'h0, timerCompOut, timerGate});
    @(posedge clk);
    timerClkTick <= 1'b1;
    @(posedge clk);
    timerClkTick <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("sync tick", 8'h03, {6'h0, timerCompOut, timerGate});
    wr(8'h01, 8'h00);
    $display("test select done");
    pinIsOutput <= 2'b11;
    portLatch <= 2'b01;
    for (int s = 0; s < 4; s++) begin
      wr(8'h00, s == 0 ? 8'h00 : s == 1 ? 8'h20 : 8'ha0);
      plusLevel <= s == 3 ? 8'h90 : 8'h40;
      repeat (8) @(posedge clk);
      #1;
      chk("pin", (s == 0 || s == 3) ? 8'h0d : 8'h0c, {4'h0, pinOe, pinOut});
    end
    $display("test pin done");
    wr(8'h04, 8'h08);
    wr(8'h05, 8'hc0);
    rd(8'h00, 8'he0, "snapshot");
    wr(8'h03, 8'h00);
    step(8'h90, 8'h00, 2'b00, "quiet");
    step(8'h40, 8'h08, 2'b11, "change");
    wr(8'h03, 8'h00);
    step(8'h40, 8'h00, 2'b00, "held");
    step(8'h90, 8'h00, 2'b00, "back");
    step(8'h40, 8'h08, 2'b11, "again");
    rd(8'h00, 8'ha0, "equalize");
    wr(8'h03, 8'h00);
    step(8'h90, 8'h08, 2'b11, "after read");
    wr(8'h00, 8'ha0);
    wr(8'h03, 8'h00);
    step(8'h40, 8'h08, 2'b11, "after write");
    wr(8'h05, 8'h40);
    step(8'h40, 8'h08, 2'b10, "no global");
    wr(8'h03, 8'h00);
    wr(8'h03, 8'h08);
    step(8'h40, 8'h08, 2'b10, "soft set");
    $display("test interrupt done");
    end_sim;
  end
endmodule // test_dcc_comparator_ctrl
`default_nettype wire
